// [logic/sensor_stats_regs.svh]
`ifndef SENSOR_STATS_REGS_SVH
`define SENSOR_STATS_REGS_SVH

// Register addresses on the serial port (7-bit).
`define ADDR_DX 7'h03
`define ADDR_DY 7'h04
`define ADDR_SHUTTER_HIGH 7'h06
`define ADDR_SHUTTER_LOW 7'h07
`define ADDR_PEAK 7'h08
`define ADDR_SUM 7'h09
`define ADDR_FLOOR 7'h0a
`define ADDR_GRAB 7'h0b
`define ADDR_MHI 7'h0c
`define ADDR_CTRL 7'h0d
`define ADDR_DOWNSHIFT 7'h0e
`define ADDR_IDLE1 7'h0f

// Reset values.
`define RST_SHUTTER 16'h0064
`define RST_PEAK 8'hd0
`define RST_SUM 8'h80
`define RST_FLOOR 8'h00
`define RST_CTRL 8'h01
`define RST_DOWNSHIFT 8'h08
`define RST_IDLE1 8'h01

// Control register fields.
`define CTRL_WIDTH_BIT 7
`define CTRL_DPI_EN_BIT 5
`define CTRL_DPI_HI 4
`define CTRL_DPI_LO 2
`define CTRL_POWER_DOWN_BIT 1
`define CTRL_FALLBACK_BIT 0
`define CTRL_WRITE_MASK 8'hbf
`define DPI_CODE_500 3'h2
`define DPI_CODE_1250 3'h3

// Frame statistics.
`define PIX_LIMIT 8'hfe
`define SUM_HI 16
`define SUM_LO 9
`define GRAB_VALID_BIT 7

// Power-save timing.
`define DOWNSHIFT_SHIFT 3
`define IDLE1_MIN 8'h01
`define IDLE1_MAX 8'hfd
`define IDLE1_TICK_MS 10

// Exposure control.
`define AE_PEAK_HIGH 8'hf0
`define AE_SUM_LOW 8'h40
`define SHUTTER_MIN 16'h0008
`define SHUTTER_CAP 16'he000

// Motion saturation limits.
`define MOTION_MAX12 13'h07ff
`define MOTION_MIN12 13'h1800
`define MOTION_MAX8 13'h007f
`define MOTION_MIN8 13'h1f80

`endif

// [logic/sensor_stats_pkg.sv]
package sensor_stats_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] reg_addr_t;
  typedef logic [11:0] motion_t;
  typedef logic [2:0] dpi_code_t;
endpackage : sensor_stats_pkg

// [logic/serial_xfer_if.sv]
`timescale 1ns/1ps
interface serial_xfer_if;
  import sensor_stats_pkg::*;
  logic req_tgl;
  reg_addr_t req_addr;
  logic req_write;
  byte_t req_wdata;
  byte_t rd_data;
  modport link (output req_tgl, output req_addr, output req_write, output req_wdata, input rd_data);
  modport core (input req_tgl, input req_addr, input req_write, input req_wdata, output rd_data);
endinterface : serial_xfer_if

// [logic/serial_link.sv]
`timescale 1ns/1ps
module serial_link
  import sensor_stats_pkg::*;
(
  input wire logic sclk_i, // Serial clock from the controller.
  input wire logic ncs_i, // Chip select, active low.
  input wire logic mosi_i, // Serial data in.
  input wire logic rst_i, // Asynchronous reset, active high.
  serial_xfer_if.link lk, // Requests towards the core domain.
  output logic miso_o, // Serial data out.
  output logic miso_oe_o // High while the data out pin is driven.
);
  // Deselecting the device ends the frame; no sclk edge is needed for that.
  logic frame_rst;
  logic [3:0] cnt_ff, nxt_cnt;
  byte_t shift_ff, nxt_shift;
  logic tgl_ff, nxt_tgl;
  reg_addr_t addr_ff, nxt_addr;
  logic write_ff, nxt_write;
  byte_t wdata_ff, nxt_wdata;
  byte_t out_ff, nxt_out;
  logic miso_ff, nxt_miso;
  logic oe_ff, nxt_oe;
  byte_t in_byte;

  assign frame_rst = rst_i | ncs_i;
  assign in_byte = {shift_ff[6:0], mosi_i};

  always_comb begin
    nxt_cnt = cnt_ff + 4'h1;
    nxt_shift = in_byte;
    nxt_tgl = tgl_ff;
    nxt_addr = addr_ff;
    nxt_write = write_ff;
    nxt_wdata = wdata_ff;
    if (cnt_ff == 4'h7) begin
      nxt_addr = in_byte[6:0];
      nxt_write = in_byte[7];
      if (!in_byte[7]) begin
        nxt_tgl = ~tgl_ff;
      end
    end else if (cnt_ff == 4'hf && write_ff) begin
      nxt_wdata = in_byte;
      nxt_tgl = ~tgl_ff;
    end
  end

  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
    end
  end

  // Request fields outlive the frame so the core can sample them after the toggle.
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_ff <= 1'b0;
      addr_ff <= 7'h00;
      write_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      tgl_ff <= nxt_tgl;
      addr_ff <= nxt_addr;
      write_ff <= nxt_write;
      wdata_ff <= nxt_wdata;
    end
  end

  // Read data are sampled only after the controller's address-to-data pause,
  // by which time the core has settled them and holds them until the next request.
  always_comb begin
    nxt_out = {out_ff[6:0], 1'b0};
    nxt_miso = out_ff[6];
    nxt_oe = oe_ff;
    if (cnt_ff == 4'h8 && !write_ff) begin
      nxt_out = lk.rd_data;
      nxt_miso = lk.rd_data[7];
      nxt_oe = 1'b1;
    end
  end

  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      out_ff <= 8'h00;
      miso_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      miso_ff <= nxt_miso;
      oe_ff <= nxt_oe;
    end
  end

  assign lk.req_tgl = tgl_ff;
  assign lk.req_addr = addr_ff;
  assign lk.req_write = write_ff;
  assign lk.req_wdata = wdata_ff;
  assign miso_o = miso_ff;
  assign miso_oe_o = oe_ff;
endmodule : serial_link

// [logic/image_stats_regs.sv]
`timescale 1ns/1ps
`include "sensor_stats_regs.svh"
// Functional notes
// RL1: Shutter time is 16-bit clock cycles, auto-adjusted; low byte resets 0x64.
// RL2: Controller reads shutter high byte, then low byte, consecutively.
// RL3: Peak register holds frame maximum pixel 0..254; resets 0xd0.
// RL4: Floor register holds frame minimum pixel 0..254; resets 0x00.
// RL5: Sum register shows bits 16:9 of the 17-bit frame pixel sum.
// RL6: Grabber captures one pixel per frame; bit 7 flags valid 7-bit data.
// RL7: Grabber advances one position per grabbed read; 484 reads cover 22x22.
// RL8: Any write to the grabber register returns it to position 0.
// RL9: Controller keeps the sensor still during the 484 grabber reads.
// RL10: Upper nibbles of X (7:4) and Y (3:0) extend low bytes to 12 bits.
// RL11: Controller reads X low, Y low, then nibble register consecutively.
// RL12: Control bit 7 selects 8-bit (0) or 12-bit (1) motion reporting.
// RL13: With bit 5 set, bits 4:2 choose resolution code 0..6; a written code 7 is passed through as 7.
// RL14: Bit 0 picks 500 or 1250 dpi; ignored when bit 5 set; reset 0x01.
// RL15: Idle1 entry time is register value times 8 position periods; reset 0x08.
// RL16: Idle1 period is value plus one slow ticks; valid 0x01..0xfd; reset 0x01.
// RL17: Controller brackets timing writes with 0x40 then 0x00 to register 0x22.
// RL18: Reading a low motion byte clears that axis; bytes are two's complement.
// RL19: A read of a valid grabbed pixel clears valid until next capture.
module image_stats_regs
  import sensor_stats_pkg::*;
#(
  parameter int ARRAY_SIDE = 22
) (
  input wire logic clk_i, // Core clock, 40 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic ce_i, // Clock enable; low freezes core state.
  input wire logic sclk_i, // Serial clock from the controller.
  input wire logic ncs_i, // Chip select, active low.
  input wire logic mosi_i, // Serial data in.
  output logic miso_o, // Serial data out.
  output logic miso_oe_o, // Serial data out enable.
  input wire logic frame_start_i, // Pulse before a frame's first pixel.
  input wire logic frame_end_i, // Pulse after a frame's last pixel.
  input wire logic pix_stb_i, // Pixel strobe.
  input wire logic [7:0] pix_data_i, // Pixel value.
  input wire logic motion_stb_i, // Per-frame motion strobe.
  input wire logic [7:0] motion_dx_i, // Signed X displacement of a frame.
  input wire logic [7:0] motion_dy_i, // Signed Y displacement of a frame.
  output logic [15:0] shutter_o, // Shutter open time in clock cycles.
  output logic report_12bit_o, // Twelve-bit motion reporting selected.
  output logic [2:0] resolution_sel_o, // Effective resolution code.
  output logic power_down_o, // Power down request.
  output logic [10:0] idle1_entry_o, // Idle1 entry time in position periods.
  output logic [8:0] idle1_ticks_o // Idle1 period in slow-clock ticks.
);
  localparam int PIXELS = ARRAY_SIDE * ARRAY_SIDE;
  localparam logic [8:0] GRAB_LAST = 9'(PIXELS - 1);

  serial_xfer_if lk ();

  serial_link u_link (
    .sclk_i(sclk_i),
    .ncs_i(ncs_i),
    .mosi_i(mosi_i),
    .rst_i(rst_i),
    .lk(lk.link),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o)
  );

  // Saturating add of a frame displacement to an axis count.
  function automatic motion_t accumulate(input motion_t acc, input byte_t delta, input logic wide);
    logic [12:0] sum;
    logic [12:0] hi;
    logic [12:0] lo;
    sum = {acc[11], acc} + {{5{delta[7]}}, delta};
    hi = wide ? `MOTION_MAX12 : `MOTION_MAX8;
    lo = wide ? `MOTION_MIN12 : `MOTION_MIN8;
    if (!sum[12] && sum > hi) begin
      sum = hi;
    end else if (sum[12] && sum < lo) begin
      sum = lo;
    end
    accumulate = sum[11:0];
  endfunction : accumulate

  function automatic dpi_code_t dpi_select(input byte_t ctrl);
    if (ctrl[`CTRL_DPI_EN_BIT]) begin
      dpi_select = ctrl[`CTRL_DPI_HI:`CTRL_DPI_LO]; // RL13
    end else begin
      dpi_select = ctrl[`CTRL_FALLBACK_BIT] ? `DPI_CODE_1250 : `DPI_CODE_500; // RL14
    end
  endfunction : dpi_select

  logic [2:0] sync_ff, nxt_sync;
  byte_t rd_data_ff, nxt_rd_data;
  logic [15:0] shutter_ff, nxt_shutter;
  byte_t shadow_ff, nxt_shadow;
  logic shadow_ok_ff, nxt_shadow_ok;
  byte_t peak_ff, nxt_peak;
  byte_t sum_up_ff, nxt_sum_up;
  byte_t floor_ff, nxt_floor;
  byte_t run_max_ff, nxt_run_max;
  byte_t run_min_ff, nxt_run_min;
  logic [16:0] run_sum_ff, nxt_run_sum;
  logic [8:0] pix_cnt_ff, nxt_pix_cnt;
  logic [8:0] grab_pos_ff, nxt_grab_pos;
  logic [6:0] grab_tmp_ff, nxt_grab_tmp;
  logic grab_hit_ff, nxt_grab_hit;
  logic [6:0] grab_val_ff, nxt_grab_val;
  logic valid_ff, nxt_valid;
  motion_t acc_x_ff, nxt_acc_x;
  motion_t acc_y_ff, nxt_acc_y;
  logic [3:0] x_hi_ff, nxt_x_hi;
  logic [3:0] y_hi_ff, nxt_y_hi;
  byte_t ctrl_ff, nxt_ctrl;
  byte_t downshift_ff, nxt_downshift;
  byte_t idle1_ff, nxt_idle1;
  dpi_code_t dpi_sel_ff, nxt_dpi_sel;
  logic [10:0] entry_ff, nxt_entry;
  logic [8:0] ticks_ff, nxt_ticks;

  logic req_edge;
  byte_t pix;
  byte_t idle1_eff;

  // Only the second and third stages of the request synchroniser are compared.
  assign req_edge = sync_ff[1] ^ sync_ff[2];
  assign pix = (pix_data_i > `PIX_LIMIT) ? `PIX_LIMIT : pix_data_i;

  always_comb begin
    nxt_sync = {sync_ff[1:0], lk.req_tgl};
    nxt_rd_data = rd_data_ff;
    nxt_shutter = shutter_ff;
    nxt_shadow = shadow_ff;
    nxt_shadow_ok = shadow_ok_ff;
    nxt_peak = peak_ff;
    nxt_sum_up = sum_up_ff;
    nxt_floor = floor_ff;
    nxt_run_max = run_max_ff;
    nxt_run_min = run_min_ff;
    nxt_run_sum = run_sum_ff;
    nxt_pix_cnt = pix_cnt_ff;
    nxt_grab_pos = grab_pos_ff;
    nxt_grab_tmp = grab_tmp_ff;
    nxt_grab_hit = grab_hit_ff;
    nxt_grab_val = grab_val_ff;
    nxt_valid = valid_ff;
    nxt_acc_x = acc_x_ff;
    nxt_acc_y = acc_y_ff;
    nxt_x_hi = x_hi_ff;
    nxt_y_hi = y_hi_ff;
    nxt_ctrl = ctrl_ff;
    nxt_downshift = downshift_ff;
    nxt_idle1 = idle1_ff;

    // Running statistics of the frame in progress.
    if (frame_start_i) begin
      nxt_run_max = 8'h00;
      nxt_run_min = `PIX_LIMIT;
      nxt_run_sum = 17'h00000;
      nxt_pix_cnt = 9'h000;
      nxt_grab_hit = 1'b0;
    end else if (pix_stb_i) begin
      if (pix > run_max_ff) begin
        nxt_run_max = pix; // RL3
      end
      if (pix < run_min_ff) begin
        nxt_run_min = pix; // RL4
      end
      nxt_run_sum = run_sum_ff + {9'h000, pix}; // RL5
      if (pix_cnt_ff == grab_pos_ff && !grab_hit_ff) begin
        nxt_grab_tmp = pix[7:1]; // RL6
        nxt_grab_hit = 1'b1;
      end
      nxt_pix_cnt = pix_cnt_ff + 9'h001;
    end

    // Publish at frame end; exposure follows the frame just finished.
    if (frame_end_i) begin
      nxt_peak = run_max_ff; // RL3
      nxt_floor = run_min_ff; // RL4
      nxt_sum_up = run_sum_ff[`SUM_HI:`SUM_LO]; // RL5
      if (run_max_ff > `AE_PEAK_HIGH && shutter_ff > `SHUTTER_MIN) begin
        nxt_shutter = shutter_ff - (shutter_ff >> 3); // RL1
      end else if (run_sum_ff[`SUM_HI:`SUM_LO] < `AE_SUM_LOW && shutter_ff < `SHUTTER_CAP) begin
        nxt_shutter = shutter_ff + (shutter_ff >> 3) + 16'h0001; // RL1
      end
      if (grab_hit_ff && !valid_ff) begin
        nxt_grab_val = grab_tmp_ff; // RL6
        nxt_valid = 1'b1; // RL6
      end
    end

    if (motion_stb_i) begin
      nxt_acc_x = accumulate(acc_x_ff, motion_dx_i, ctrl_ff[`CTRL_WIDTH_BIT]); // RL12
      nxt_acc_y = accumulate(acc_y_ff, motion_dy_i, ctrl_ff[`CTRL_WIDTH_BIT]); // RL12
    end

    if (req_edge) begin
      if (lk.req_write) begin
        case (lk.req_addr)
          `ADDR_GRAB: begin
            nxt_grab_pos = 9'h000; // RL8
            nxt_grab_hit = 1'b0; // RL8
            nxt_valid = 1'b0; // RL8
          end
          `ADDR_CTRL: nxt_ctrl = lk.req_wdata & `CTRL_WRITE_MASK;
          `ADDR_DOWNSHIFT: nxt_downshift = lk.req_wdata; // RL17
          `ADDR_IDLE1: nxt_idle1 = lk.req_wdata; // RL17
          default: nxt_ctrl = ctrl_ff;
        endcase
      end else begin
        case (lk.req_addr)
          `ADDR_DX: begin
            nxt_rd_data = acc_x_ff[7:0]; // RL18
            nxt_x_hi = acc_x_ff[11:8]; // RL10
            // A displacement arriving with the read starts the new count.
            nxt_acc_x = motion_stb_i ? accumulate(12'h000, motion_dx_i, ctrl_ff[`CTRL_WIDTH_BIT]) : 12'h000; // RL18
          end
          `ADDR_DY: begin
            nxt_rd_data = acc_y_ff[7:0]; // RL18
            nxt_y_hi = acc_y_ff[11:8]; // RL10
            nxt_acc_y = motion_stb_i ? accumulate(12'h000, motion_dy_i, ctrl_ff[`CTRL_WIDTH_BIT]) : 12'h000; // RL18
          end
          `ADDR_SHUTTER_HIGH: begin
            nxt_rd_data = shutter_ff[15:8]; // RL2
            nxt_shadow = shutter_ff[7:0]; // RL2
            nxt_shadow_ok = 1'b1;
          end
          `ADDR_SHUTTER_LOW: begin
            nxt_rd_data = shadow_ok_ff ? shadow_ff : shutter_ff[7:0]; // RL1
            nxt_shadow_ok = 1'b0;
          end
          `ADDR_PEAK: nxt_rd_data = peak_ff;
          `ADDR_SUM: nxt_rd_data = sum_up_ff;
          `ADDR_FLOOR: nxt_rd_data = floor_ff;
          `ADDR_GRAB: begin
            nxt_rd_data = {valid_ff, valid_ff ? grab_val_ff : 7'h00}; // RL6
            if (valid_ff) begin
              nxt_valid = 1'b0; // RL19
              nxt_grab_hit = 1'b0; // RL19
              nxt_grab_pos = (grab_pos_ff == GRAB_LAST) ? 9'h000 : grab_pos_ff + 9'h001; // RL7
            end
          end
          `ADDR_MHI: nxt_rd_data = {x_hi_ff, y_hi_ff}; // RL10
          `ADDR_CTRL: nxt_rd_data = ctrl_ff;
          `ADDR_DOWNSHIFT: nxt_rd_data = downshift_ff;
          `ADDR_IDLE1: nxt_rd_data = idle1_ff;
          default: nxt_rd_data = 8'h00;
        endcase
      end
    end

    // Out-of-range Idle1 period settings are held inside the valid span.
    idle1_eff = nxt_idle1;
    if (nxt_idle1 < `IDLE1_MIN) begin
      idle1_eff = `IDLE1_MIN;
    end else if (nxt_idle1 > `IDLE1_MAX) begin
      idle1_eff = `IDLE1_MAX;
    end
    nxt_ticks = {1'b0, idle1_eff} + 9'h001; // RL16
    nxt_entry = {nxt_downshift, 3'h0}; // RL15
    nxt_dpi_sel = dpi_select(nxt_ctrl); // RL13 RL14
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_ff <= 3'h0;
      rd_data_ff <= 8'h00;
      shutter_ff <= `RST_SHUTTER; // RL1
      shadow_ff <= 8'h00;
      shadow_ok_ff <= 1'b0;
      peak_ff <= `RST_PEAK; // RL3
      sum_up_ff <= `RST_SUM;
      floor_ff <= `RST_FLOOR; // RL4
      run_max_ff <= 8'h00;
      run_min_ff <= `PIX_LIMIT;
      run_sum_ff <= 17'h00000;
      pix_cnt_ff <= 9'h000;
      grab_pos_ff <= 9'h000;
      grab_tmp_ff <= 7'h00;
      grab_hit_ff <= 1'b0;
      grab_val_ff <= 7'h00;
      valid_ff <= 1'b0;
      acc_x_ff <= 12'h000;
      acc_y_ff <= 12'h000;
      x_hi_ff <= 4'h0;
      y_hi_ff <= 4'h0;
      ctrl_ff <= `RST_CTRL; // RL14
      downshift_ff <= `RST_DOWNSHIFT; // RL15
      idle1_ff <= `RST_IDLE1; // RL16
      dpi_sel_ff <= `DPI_CODE_1250;
      entry_ff <= 11'h040;
      ticks_ff <= 9'h002;
    end else if (ce_i) begin
      sync_ff <= nxt_sync;
      rd_data_ff <= nxt_rd_data;
      shutter_ff <= nxt_shutter;
      shadow_ff <= nxt_shadow;
      shadow_ok_ff <= nxt_shadow_ok;
      peak_ff <= nxt_peak;
      sum_up_ff <= nxt_sum_up;
      floor_ff <= nxt_floor;
      run_max_ff <= nxt_run_max;
      run_min_ff <= nxt_run_min;
      run_sum_ff <= nxt_run_sum;
      pix_cnt_ff <= nxt_pix_cnt;
      grab_pos_ff <= nxt_grab_pos;
      grab_tmp_ff <= nxt_grab_tmp;
      grab_hit_ff <= nxt_grab_hit;
      grab_val_ff <= nxt_grab_val;
      valid_ff <= nxt_valid;
      acc_x_ff <= nxt_acc_x;
      acc_y_ff <= nxt_acc_y;
      x_hi_ff <= nxt_x_hi;
      y_hi_ff <= nxt_y_hi;
      ctrl_ff <= nxt_ctrl;
      downshift_ff <= nxt_downshift;
      idle1_ff <= nxt_idle1;
      dpi_sel_ff <= nxt_dpi_sel;
      entry_ff <= nxt_entry;
      ticks_ff <= nxt_ticks;
    end
  end

  assign lk.rd_data = rd_data_ff;
  assign shutter_o = shutter_ff;
  assign report_12bit_o = ctrl_ff[`CTRL_WIDTH_BIT]; // RL12
  assign power_down_o = ctrl_ff[`CTRL_POWER_DOWN_BIT];
  assign resolution_sel_o = dpi_sel_ff;
  assign idle1_entry_o = entry_ff;
  assign idle1_ticks_o = ticks_ff;
endmodule : image_stats_regs

// [bench/image_stats_regs_properties.sv]
`timescale 1ns/1ps
module image_stats_regs_properties (
  input wire logic clk_i, // Core clock.
  input wire logic rst_i, // Asynchronous reset.
  input wire logic ce_i, // Clock enable.
  input wire logic frame_end_i, // End of frame pulse.
  input wire logic [15:0] shutter_o, // Shutter time.
  input wire logic [2:0] resolution_sel_o, // Resolution code.
  input wire logic [10:0] idle1_entry_o, // Idle1 entry time.
  input wire logic [8:0] idle1_ticks_o // Idle1 period.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_shut_rst; $fell(rst_i) |-> shutter_o == 16'h0064; endproperty
  a_shut_rst: assert property (p_shut_rst) else $error("shutter reset value wrong");
  property p_res_rst; $fell(rst_i) |-> resolution_sel_o == 3'h3; endproperty
  a_res_rst: assert property (p_res_rst) else $error("resolution reset value wrong");
  property p_idle_rst; $fell(rst_i) |-> idle1_entry_o == 11'h040 && idle1_ticks_o == 9'h002; endproperty
  a_idle_rst: assert property (p_idle_rst) else $error("idle timing reset value wrong");
  // The shutter may only move as the result of a frame just finished.
  property p_shut_cause; $changed(shutter_o) |-> $past(frame_end_i) && $past(ce_i); endproperty
  a_shut_cause: assert property (p_shut_cause) else $error("shutter moved without frame end");
  property p_shut_step;
    $changed(shutter_o) |-> shutter_o == $past(shutter_o) - ($past(shutter_o) >> 3) ||
      shutter_o == $past(shutter_o) + ($past(shutter_o) >> 3) + 16'h0001;
  endproperty
  a_shut_step: assert property (p_shut_step) else $error("shutter step size wrong");
  property p_entry_mult; $changed(idle1_entry_o) |-> idle1_entry_o[2:0] == 3'h0 && $past(ce_i); endproperty
  a_entry_mult: assert property (p_entry_mult) else $error("idle1 entry not a multiple of 8");
  property p_ticks_range; idle1_ticks_o inside {[9'h002:9'h0fe]}; endproperty
  a_ticks_range: assert property (p_ticks_range) else $error("idle1 period out of range");
  property p_res_code; resolution_sel_o != 3'h7; endproperty
  a_res_code: assert property (p_res_code) else $error("undefined resolution code");
  c_shut: cover property ($changed(shutter_o));
  c_res6: cover property (resolution_sel_o == 3'h6);
  c_ticks: cover property ($changed(idle1_ticks_o));
endmodule : image_stats_regs_properties

bind image_stats_regs image_stats_regs_properties i_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .frame_end_i(frame_end_i),
  .shutter_o(shutter_o),
  .resolution_sel_o(resolution_sel_o),
  .idle1_entry_o(idle1_entry_o),
  .idle1_ticks_o(idle1_ticks_o)
);

// [bench/serial_host_model.sv]
`timescale 1ns/1ps
module serial_host_model (
  output logic sclk_o, // Serial clock, idles high.
  output logic ncs_n_o, // Chip select, active low.
  output logic mosi_o, // Serial data to the device.
  input wire logic miso_i, // Serial data from the device.
  input wire logic miso_oe_i // High while the device drives miso_i.
);
  initial begin
    sclk_o = 1'b1;
    ncs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // The 200 ns pause after the address byte gives the core time to fetch read data.
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {wr, addr, wdata};
    rdata = 8'h00;
    ncs_n_o = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = (wr || i > 7) ? bits[i] : ~mosi_o;
      #24;
      sclk_o = 1'b1;
      if (!wr && i < 8) rdata[i] = miso_oe_i ? miso_i : 1'bx;
      #24;
      if (!wr && i == 8) #200;
    end
    ncs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #150;
  endtask : xfer
endmodule : serial_host_model

// [bench/image_stats_regs_tb.sv]
`timescale 1ns/1ps
`include "sensor_stats_regs.svh"
module image_stats_regs_tb;
  import sensor_stats_pkg::*;
  localparam int SIDE = 4;
  localparam int NPIX = SIDE * SIDE;
  logic clk_i = 1'b0;
  logic rst_i;
  logic ce_i = 1'b1;
  logic frame_start_i = 1'b0;
  logic frame_end_i = 1'b0;
  logic pix_stb_i = 1'b0;
  logic motion_stb_i = 1'b0;
  logic [7:0] pix_data_i = 8'h00;
  logic [7:0] motion_dx_i = 8'h00;
  logic [7:0] motion_dy_i = 8'h00;
  wire logic sclk, ncs_n, mosi, miso, miso_oe, report_12bit_o, power_down_o;
  wire logic [15:0] shutter_o;
  wire logic [2:0] resolution_sel_o;
  wire logic [10:0] idle1_entry_o;
  wire logic [8:0] idle1_ticks_o;
  int mismatches = 0;
  int n_tests = 0;
  byte_t rdata;
  logic [16:0] sum;

  always #12.5 clk_i = ~clk_i;

  image_stats_regs #(.ARRAY_SIDE(SIDE)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk),
    .ncs_i(ncs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .frame_start_i(frame_start_i),
    .frame_end_i(frame_end_i), .pix_stb_i(pix_stb_i), .pix_data_i(pix_data_i), .motion_stb_i(motion_stb_i),
    .motion_dx_i(motion_dx_i), .motion_dy_i(motion_dy_i), .shutter_o(shutter_o),
    .report_12bit_o(report_12bit_o), .resolution_sel_o(resolution_sel_o), .power_down_o(power_down_o),
    .idle1_entry_o(idle1_entry_o), .idle1_ticks_o(idle1_ticks_o));
  serial_host_model i_host (.sclk_o(sclk), .ncs_n_o(ncs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

  function automatic byte_t pix(input int i);
    return 8'(i * 16 + 15);
  endfunction : pix
  function automatic byte_t grab(input int i);
    byte_t p;
    p = pix(i);
    return {1'b1, p[7:1]};
  endfunction : grab

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input reg_addr_t a, input byte_t exp);
    i_host.xfer(1'b0, a, 8'h00, rdata);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd
  task automatic wr(input reg_addr_t a, input byte_t d);
    i_host.xfer(1'b1, a, d, rdata);
    repeat (8) @(posedge clk_i);
  endtask : wr
  task automatic wr_idle(input reg_addr_t a, input byte_t d);
    wr(7'h22, 8'h40);
    wr(a, d);
    wr(7'h22, 8'h00);
  endtask : wr_idle
  // Every frame carries the same pixels, as if the sensor were held still.
  task automatic frame;
    @(posedge clk_i);
    frame_start_i <= 1'b1;
    for (int i = 0; i < NPIX; i++) begin
      @(posedge clk_i);
      frame_start_i <= 1'b0;
      pix_stb_i <= 1'b1;
      pix_data_i <= pix(i);
    end
    @(posedge clk_i);
    pix_stb_i <= 1'b0;
    frame_end_i <= 1'b1;
    @(posedge clk_i);
    frame_end_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : frame
  task automatic mot(input byte_t dx, input byte_t dy);
    @(posedge clk_i);
    motion_stb_i <= 1'b1;
    motion_dx_i <= dx;
    motion_dy_i <= dy;
    @(posedge clk_i);
    motion_stb_i <= 1'b0;
  endtask : mot
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    #500000;
    mismatches++;
    print_verdict;
  end

  initial begin
    // Set by a non-blocking update so that every reset process sees a rising edge.
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(`ADDR_SHUTTER_HIGH, 8'h00);
    rd(`ADDR_SHUTTER_LOW, 8'h64);
    rd(`ADDR_PEAK, 8'hd0);
    rd(`ADDR_SUM, 8'h80);
    rd(`ADDR_FLOOR, 8'h00);
    rd(`ADDR_GRAB, 8'h00);
    rd(`ADDR_MHI, 8'h00);
    rd(`ADDR_CTRL, 8'h01);
    rd(`ADDR_DOWNSHIFT, 8'h08);
    rd(`ADDR_IDLE1, 8'h01);
    rd(7'h20, 8'h00);
    frame;
    sum = 17'h0;
    for (int i = 0; i < NPIX; i++) sum += 17'(pix(i) == 8'hff ? 8'hfe : pix(i));
    rd(`ADDR_PEAK, 8'hfe);
    rd(`ADDR_FLOOR, 8'h0f);
    rd(`ADDR_SUM, sum[16:9]);
    chk(shutter_o, 16'h0058);
    // A frame seen while the clock enable is low must leave the exposure alone.
    @(posedge clk_i);
    ce_i <= 1'b0;
    frame;
    ce_i <= 1'b1;
    chk(shutter_o, 16'h0058);
    rd(`ADDR_SHUTTER_HIGH, 8'h00);
    rd(`ADDR_SHUTTER_LOW, 8'h58);
    wr(`ADDR_PEAK, 8'h12);
    rd(`ADDR_PEAK, 8'hfe);
    rd(`ADDR_GRAB, grab(0));
    rd(`ADDR_GRAB, 8'h00);
    for (int k = 1; k <= NPIX; k++) begin
      frame;
      rd(`ADDR_GRAB, grab(k % NPIX));
    end
    frame;
    wr(`ADDR_GRAB, 8'h5a);
    rd(`ADDR_GRAB, 8'h00);
    frame;
    rd(`ADDR_GRAB, grab(0));
    wr(`ADDR_CTRL, 8'h80);
    chk(16'(report_12bit_o), 16'h0001);
    mot(8'h70, 8'hf0);
    mot(8'h70, 8'hf0);
    rd(`ADDR_DX, 8'he0);
    rd(`ADDR_DY, 8'he0);
    rd(`ADDR_MHI, 8'h0f);
    rd(`ADDR_DX, 8'h00);
    wr(`ADDR_CTRL, 8'h00);
    chk(16'(report_12bit_o), 16'h0000);
    chk(16'(resolution_sel_o), 16'h0002);
    mot(8'h70, 8'h10);
    mot(8'h70, 8'h10);
    rd(`ADDR_DX, 8'h7f);
    rd(`ADDR_DY, 8'h20);
    for (int c = 0; c < 7; c++) begin
      wr(`ADDR_CTRL, {3'b001, 3'(c), 2'b01});
      chk(16'(resolution_sel_o), 16'(c));
    end
    wr(`ADDR_CTRL, 8'hdb);
    rd(`ADDR_CTRL, 8'h9b);
    chk(16'(resolution_sel_o), 16'h0003);
    chk(16'(power_down_o), 16'h0001);
    wr_idle(`ADDR_DOWNSHIFT, 8'h10);
    chk(16'(idle1_entry_o), 16'h0080);
    rd(`ADDR_DOWNSHIFT, 8'h10);
    wr_idle(`ADDR_IDLE1, 8'hfd);
    chk(16'(idle1_ticks_o), 16'h00fe);
    wr_idle(`ADDR_IDLE1, 8'h00);
    chk(16'(idle1_ticks_o), 16'h0002);
    print_verdict;
  end
endmodule : image_stats_regs_tb
